// ===== rtl/rdcs_cfg.svh
// Offsets, field positions and timing counts of the reset sequencer.
`ifndef RDCS_CFG_SVH
`define RDCS_CFG_SVH
`define RDCS_ADDR_WIDTH        12
`define RDCS_SHARED_OFFSET     12'hFF0
`define RDCS_CTRL_OFFSET       12'hFF4
`define RDCS_BIT_POR           7
`define RDCS_BIT_STOP          6
`define RDCS_BIT_WDOG          5
`define RDCS_BIT_PIN           4
`define RDCS_CTRL_BIT_XTAL_OFF 0
`define RDCS_CTRL_BIT_BO_EN    1
`define RDCS_SHORT_CYCLES      66
`define RDCS_LONG_CYCLES       5000
`define RDCS_BROWNOUT_NS       10000
`define RDCS_CLK_PERIOD_NS     5
`define RDCS_BROWNOUT_CYCLES   (`RDCS_BROWNOUT_NS / `RDCS_CLK_PERIOD_NS)
`define RDCS_RESP_OKAY         2'h0
`define RDCS_RESP_SLVERR       2'h2
`endif

// ===== rtl/rdcs_pkg.sv
// Types shared by the reset sequencer modules.
`default_nettype none
package rdcs_pkg;
	typedef enum logic [2:0] {
		RDCS_IDLE    = 3'b001,
		RDCS_STRETCH = 3'b010,
		RDCS_RUN     = 3'b100
	} rdcs_state_t;
	typedef enum logic [1:0] {
		RDCS_CAUSE_POR  = 2'h0,
		RDCS_CAUSE_STOP = 2'h1,
		RDCS_CAUSE_WDOG = 2'h2,
		RDCS_CAUSE_PIN  = 2'h3
	} rdcs_cause_t;
endpackage : rdcs_pkg
`default_nettype wire

// ===== rtl/rdcs_if.sv
// Link between the reset sequencer and its stretch counter.
`default_nettype none
interface rdcs_if #(parameter int CW = 16);
	logic          start;
	logic [CW-1:0] load;
	logic          tick;
	logic          busy;
	modport ctrl (output start, output load, output tick, input busy);
	modport cnt  (input start, input load, input tick, output busy);
endinterface : rdcs_if
`default_nettype wire

// ===== rtl/rdcs_counter.sv
// Down counter that stretches reset by a loaded number of oscillator ticks.
`default_nettype none
module rdcs_counter #(
	parameter int CW = 16
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Sequencer link
	rdcs_if.cnt       lnk
);
	logic [CW-1:0] count_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_ff <= '0;
		end else if (lnk.start) begin
			count_ff <= lnk.load;
		end else if (lnk.tick && count_ff != '0) begin
			count_ff <= count_ff - 1'b1;
		end
	end

	assign lnk.busy = (count_ff != '0);
endmodule : rdcs_counter
`default_nettype wire

// ===== rtl/rdcs_top.sv
// Reset stretcher, brown-out filter and reset cause status with AXI4-Lite access.
`include "rdcs_cfg.svh"
`default_nettype none
module rdcs_top #(
	parameter int CW            = 16,
	parameter int SHORT_CYCLES  = `RDCS_SHORT_CYCLES,
	parameter int LONG_CYCLES   = `RDCS_LONG_CYCLES,
	parameter int BROWN_CYCLES  = `RDCS_BROWNOUT_CYCLES
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Reset sources, asynchronous
	input  wire logic        osc_tick,
	input  wire logic        supply_low,
	input  wire logic        pin_reset_n,
	input  wire logic        watchdog_expired,
	input  wire logic        stop_wake,
	// Sequencer outputs
	output var  logic        core_reset_n,
	output var  logic        crystal_enable,
	output var  logic [7:0]  watchdog_unlock_code,
	output var  logic        watchdog_code_strobe,
	// AXI4-Lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	// AXI4-Lite write response
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	// AXI4-Lite read data
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	localparam int NS = 5;
	logic [NS-1:0] sync1_ff;
	logic [NS-1:0] sync2_ff;
	logic          tick_d_ff;
	logic          tick_rise;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Idle levels, so the release raises no false trigger or tick
			sync1_ff <= 5'h04;
			sync2_ff <= 5'h04;
		end else begin
			sync1_ff <= {osc_tick, supply_low, pin_reset_n, watchdog_expired, stop_wake};
			sync2_ff <= sync1_ff;
		end
	end

	logic s_tick, s_low, s_pin_n, s_wdog, s_wake;
	assign {s_tick, s_low, s_pin_n, s_wdog, s_wake} = sync2_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_d_ff <= 1'b0;
		end else begin
			tick_d_ff <= s_tick;
		end
	end
	assign tick_rise = s_tick && !tick_d_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Control register: crystal option and brown-out enable
	logic xtal_off_ff;
	logic bo_en_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Brown-out filter; dips shorter than the window never reach the sequencer
	logic [15:0] bo_cnt_ff;
	logic        brownout_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bo_cnt_ff   <= 16'h0000;
			brownout_ff <= 1'b0;
		end else if (!s_low || !bo_en_ff) begin
			bo_cnt_ff   <= 16'h0000;
			brownout_ff <= 1'b0;
		end else if (bo_cnt_ff < 16'(BROWN_CYCLES - 1)) begin
			bo_cnt_ff   <= bo_cnt_ff + 16'h0001;
		end else begin
			brownout_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset sequencer
	rdcs_if #(.CW(CW)) lnk ();
	rdcs_pkg::rdcs_state_t state_ff;
	rdcs_pkg::rdcs_cause_t cause_ff;
	logic                  first_ff;
	logic                  trig;
	rdcs_pkg::rdcs_cause_t nxt_cause;

	// Power-on counts as the first trigger, brown-out is reported as power-on
	always_comb begin
		trig      = 1'b1;
		nxt_cause = rdcs_pkg::RDCS_CAUSE_POR;
		if (first_ff || brownout_ff) begin
			nxt_cause = rdcs_pkg::RDCS_CAUSE_POR;
		end else if (!s_pin_n) begin
			nxt_cause = rdcs_pkg::RDCS_CAUSE_PIN;
		end else if (s_wdog) begin
			nxt_cause = rdcs_pkg::RDCS_CAUSE_WDOG;
		end else if (s_wake) begin
			nxt_cause = rdcs_pkg::RDCS_CAUSE_STOP;
		end else begin
			trig = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= rdcs_pkg::RDCS_IDLE;
			cause_ff <= rdcs_pkg::RDCS_CAUSE_POR;
			first_ff <= 1'b1;
		end else begin
			unique case (state_ff)
				rdcs_pkg::RDCS_IDLE: begin
					state_ff <= rdcs_pkg::RDCS_STRETCH;
					first_ff <= 1'b0;
				end
				rdcs_pkg::RDCS_STRETCH: begin
					if (trig && !first_ff && nxt_cause != rdcs_pkg::RDCS_CAUSE_STOP) begin
						state_ff <= rdcs_pkg::RDCS_IDLE;
						cause_ff <= nxt_cause;
					end else if (!lnk.busy) begin
						state_ff <= rdcs_pkg::RDCS_RUN;
					end
				end
				rdcs_pkg::RDCS_RUN: begin
					if (trig) begin
						state_ff <= rdcs_pkg::RDCS_IDLE;
						cause_ff <= nxt_cause;
					end
				end
			endcase
		end
	end

	// Count load picks the long wait while the crystal runs in reset
	assign lnk.start = (state_ff == rdcs_pkg::RDCS_IDLE);
	assign lnk.load  = xtal_off_ff ? CW'(SHORT_CYCLES)
	                               : CW'(LONG_CYCLES);
	assign lnk.tick  = tick_rise;

	rdcs_counter #(.CW(CW)) u_counter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.lnk     (lnk)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_reset_n   <= 1'b0;
			crystal_enable <= 1'b0;
		end else begin
			core_reset_n   <= (state_ff == rdcs_pkg::RDCS_RUN) && !trig;
			crystal_enable <= !xtal_off_ff || (state_ff == rdcs_pkg::RDCS_RUN);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset cause flags, one-hot, latched at the release
	logic [3:0] flags_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_ff <= 4'h0;
		end else if (state_ff == rdcs_pkg::RDCS_STRETCH && !lnk.busy && !trig) begin
			flags_ff <= 4'h0;
			flags_ff[3 - cause_ff] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path
	logic        aw_ok_ff;
	logic        w_ok_ff;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        wr_go;

	assign wr_go = aw_ok_ff && w_ok_ff && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_ff      <= 1'b0;
			w_ok_ff       <= 1'b0;
			awaddr_ff     <= 12'h000;
			wdata_ff      <= 32'h0000_0000;
			wstrb_ff      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_ok_ff && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_ok_ff && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_ff  <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_ok_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_ff  <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (wr_go) begin
				w_ok_ff <= 1'b0;
			end
		end
	end

	logic hit_shared_w;
	logic hit_ctrl_w;
	assign hit_shared_w = ({awaddr_ff[11:2], 2'h0} == `RDCS_SHARED_OFFSET);
	assign hit_ctrl_w   = ({awaddr_ff[11:2], 2'h0} == `RDCS_CTRL_OFFSET);

	// Watchdog code has no reset value; only the strobe is defined
	always_ff @(posedge aclk) begin
		if (wr_go && hit_shared_w && wstrb_ff[0]) begin
			watchdog_unlock_code <= wdata_ff[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_code_strobe <= 1'b0;
			xtal_off_ff          <= 1'b0;
			bo_en_ff             <= 1'b1;
			s_axi_bvalid         <= 1'b0;
			s_axi_bresp          <= `RDCS_RESP_OKAY;
		end else begin
			watchdog_code_strobe <= wr_go && hit_shared_w && wstrb_ff[0];
			if (wr_go && hit_ctrl_w && wstrb_ff[0]) begin
				xtal_off_ff <= wdata_ff[`RDCS_CTRL_BIT_XTAL_OFF];
				bo_en_ff    <= wdata_ff[`RDCS_CTRL_BIT_BO_EN];
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (hit_shared_w || hit_ctrl_w) ? `RDCS_RESP_OKAY
				                                              : `RDCS_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path
	logic [11:0] rd_word;
	assign rd_word = {s_axi_araddr[11:2], 2'h0};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RDCS_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RDCS_RESP_OKAY;
				if (rd_word == `RDCS_SHARED_OFFSET) begin
					s_axi_rdata <= {24'h000000, flags_ff, 4'h0};
				end else if (rd_word == `RDCS_CTRL_OFFSET) begin
					s_axi_rdata <= {30'h0, bo_en_ff, xtal_off_ff};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `RDCS_RESP_SLVERR;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : rdcs_top
`default_nettype wire

// ===== verif/rdcs_top_asserts.sv
// Concurrent checks on the reset sequencer top-level ports.
`default_nettype none
module rdcs_top_asserts (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Reset sources and sequencer
	input wire logic        supply_low,
	input wire logic        pin_reset_n,
	input wire logic        watchdog_expired,
	input wire logic        stop_wake,
	input wire logic        core_reset_n,
	input wire logic        watchdog_code_strobe,
	// Register bus
	input wire logic        s_axi_bvalid,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [31:0] s_axi_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd_shared_ff;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_shared_ff <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_shared_ff <= s_axi_araddr[11:2] == 10'h3FC;
		end
	end
	property p_por_hold;
		$rose(aresetn) |-> !core_reset_n [*8];
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("early release");
	property p_trig_hold;
		$fell(core_reset_n) |-> !core_reset_n [*8];
	endproperty
	a_trig_hold: assert property (p_trig_hold) else $error("short stretch");
	property p_pin_fast;
		$fell(pin_reset_n) && core_reset_n |-> ##[1:6] !core_reset_n;
	endproperty
	a_pin_fast: assert property (p_pin_fast) else $error("pin ignored");
	property p_bo_short;
		$rose(supply_low) && core_reset_n && pin_reset_n && !watchdog_expired && !stop_wake
			|=> core_reset_n [*6];
	endproperty
	a_bo_short: assert property (p_bo_short) else $error("dip not filtered");
	property p_strobe;
		watchdog_code_strobe |-> s_axi_bvalid ##1 !watchdog_code_strobe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("bad code strobe");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("late read data");
	property p_rd_zero;
		s_axi_rvalid && rd_shared_ff |-> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("reserved bits set");
	property p_rd_slverr;
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
	endproperty
	a_rd_slverr: assert property (p_rd_slverr) else $error("error read data");
	cover property ($rose(core_reset_n));
	cover property (watchdog_code_strobe);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : rdcs_top_asserts
bind rdcs_top rdcs_top_asserts u_chk (
	.aclk, .aresetn, .supply_low, .pin_reset_n, .watchdog_expired, .stop_wake,
	.core_reset_n, .watchdog_code_strobe, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata
);
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the reset sequencer.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SH = 6;
	localparam int LG = 20;
	localparam int BO = 10;
	logic        aclk = 1'b0;
	logic        osc_tick = 1'b0;
	logic        aresetn, supply_low, pin_reset_n, watchdog_expired, stop_wake;
	logic        core_reset_n, crystal_enable, watchdog_code_strobe;
	logic [7:0]  watchdog_unlock_code;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          n_errors = 0;
	int          n_compared = 0;
	int          n_strobe = 0;
	int          exp_q[$];
	always #2.5 aclk = ~aclk;
	// Four bus clocks per level, as the synchroniser needs
	always #20 osc_tick = ~osc_tick;
	always @(posedge aclk) begin
		if (watchdog_code_strobe === 1'b1) begin
			n_strobe++;
		end
	end
	rdcs_top #(.SHORT_CYCLES(SH), .LONG_CYCLES(LG), .BROWN_CYCLES(BO)) dut (
		.aclk, .aresetn, .osc_tick, .supply_low, .pin_reset_n, .watchdog_expired, .stop_wake,
		.core_reset_n, .crystal_enable, .watchdog_unlock_code, .watchdog_code_strobe,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready
	);
	task automatic final_report;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic stuck(input int k);
		if (k >= 200) begin
			n_errors++;
			final_report();
		end
	endtask : stuck
	task automatic wr(input logic [11:0] a, input logic [31:0] dv, output logic [1:0] rs);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dv;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (k = 0; k < 200; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		stuck(k);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rs);
		int k;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (k = 0; k < 200; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		dv = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		stuck(k);
	endtask : rd
	// Stretch length in bus clocks, with slack for tick phase
	task automatic run_len(input int n);
		int k;
		for (k = 0; k < 2000 && !core_reset_n; k++) @(posedge aclk);
		chk("stretch", 32'(k >= n * 8 - 16 && k <= n * 8 + 40), 32'h1);
	endtask : run_len
	task automatic st;
		rd(12'hFF0, d, r);
		chk("status", d, 32'h1 << exp_q.pop_front());
	endtask : st
	task automatic por;
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("xtal_on", 32'(crystal_enable), 32'h1);
		run_len(LG);
		exp_q.push_back(7);
		st();
	endtask : por
	initial begin
		void'($urandom(32'hA1CDB7B7));
		{aresetn, supply_low, watchdog_expired, stop_wake} = 4'h0;
		pin_reset_n = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		por();
		wr(12'hFF4, 32'h3, r);
		rd(12'hFF4, d, r);
		chk("ctrl", d, 32'h3);
		for (int c = 0; c < 4; c++) begin
			@(posedge aclk);
			case (c)
				0: pin_reset_n <= 1'b0;
				1: watchdog_expired <= 1'b1;
				2: stop_wake <= 1'b1;
				default: supply_low <= 1'b1;
			endcase
			// One edge more than the trigger path, two more for the brown-out, so the crystal enable has dropped
			repeat (c == 3 ? BO + 6 : 5) @(posedge aclk);
			{pin_reset_n, watchdog_expired, stop_wake, supply_low} <= 4'h8;
			chk("xtal_off", 32'(crystal_enable), 32'h0);
			run_len(SH);
			exp_q.push_back(4 + c);
			st();
		end
		@(posedge aclk);
		supply_low <= 1'b1;
		repeat (BO / 2) @(posedge aclk);
		supply_low <= 1'b0;
		repeat (20) @(posedge aclk);
		chk("dip", 32'(core_reset_n), 32'h1);
		d = $urandom;
		wr(12'hFF0, d, r);
		chk("wresp", 32'(r), 32'h0);
		@(posedge aclk);
		#1 chk("code", 32'(watchdog_unlock_code), 32'(d[7:0]));
		chk("strobes", 32'(n_strobe), 32'h1);
		exp_q.push_back(7);
		st();
		rd(12'h800, d, r);
		chk("rslverr", 32'({d, r} == 34'h2), 32'h1);
		wr(12'h800, 32'h5A, r);
		chk("wslverr", 32'(r), 32'h2);
		// Stop recovery with the crystal kept running takes the long wait
		wr(12'hFF4, 32'h2, r);
		@(posedge aclk);
		stop_wake <= 1'b1;
		repeat (5) @(posedge aclk);
		stop_wake <= 1'b0;
		chk("xtal_on_stop", 32'(crystal_enable), 32'h1);
		run_len(LG);
		exp_q.push_back(6);
		st();
		chk("strobes_end", 32'(n_strobe), 32'h1);
		por();
		final_report();
	end
endmodule : testbench
`default_nettype wire
